// ### src/pcitw_axil_regs.sv
`timescale 1ns/10ps
`default_nettype none
`include "pcitw_params.svh"

module pcitw_axil_regs
	import pcitw_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic clkEn,
	// axi4-lite slave
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// block side
	output pcitw_cfg_t cfg,
	input wire pcitw_stat_t stat
);

	logic awHave_q, awHave_d, wHave_q, wHave_d;
	logic [3:0] awAddr_q, awAddr_d;
	logic [31:0] wData_q, wData_d;
	logic [3:0] wStrb_q, wStrb_d;
	logic bValid_q, bValid_d, rValid_q, rValid_d;
	logic [1:0] bResp_q, bResp_d, rResp_q, rResp_d;
	logic [31:0] rData_q, rData_d, ctrl_q, ctrl_d, base_q, base_d;
	logic awReady_q, awReady_d, wReady_q, wReady_d, arReady_q, arReady_d;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	always_comb begin
		awHave_d = awHave_q;
		wHave_d = wHave_q;
		awAddr_d = awAddr_q;
		wData_d = wData_q;
		wStrb_d = wStrb_q;
		bValid_d = bValid_q;
		bResp_d = bResp_q;
		rValid_d = rValid_q;
		rResp_d = rResp_q;
		rData_d = rData_q;
		ctrl_d = ctrl_q;
		base_d = base_q;
		if (s_axi_awvalid && !awHave_q && !bValid_q) begin
			awHave_d = 1'b1;
			awAddr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && !wHave_q && !bValid_q) begin
			wHave_d = 1'b1;
			wData_d = s_axi_wdata;
			wStrb_d = s_axi_wstrb;
		end
		if (awHave_q && wHave_q) begin
			awHave_d = 1'b0;
			wHave_d = 1'b0;
			bValid_d = 1'b1;
			bResp_d = `PCITW_RESP_OKAY;
			case (awAddr_q)
				`PCITW_REG_CTRL: ctrl_d = merge(ctrl_q, wData_q, wStrb_q);
				`PCITW_REG_BASE: base_d = merge(base_q, wData_q, wStrb_q);
				`PCITW_REG_STAT, `PCITW_REG_XCNT: bResp_d = `PCITW_RESP_OKAY;
				default: bResp_d = `PCITW_RESP_SLVERR;
			endcase
		end
		if (bValid_q && s_axi_bready) begin
			bValid_d = 1'b0;
		end
		if (rValid_q && s_axi_rready) begin
			rValid_d = 1'b0;
		end
		if (s_axi_arvalid && !rValid_q) begin
			rValid_d = 1'b1;
			rResp_d = `PCITW_RESP_OKAY;
			case (s_axi_araddr)
				`PCITW_REG_CTRL: rData_d = {30'h0, ctrl_q[1:0]};
				`PCITW_REG_BASE: rData_d = base_q;
				`PCITW_REG_STAT: rData_d = {13'h0, stat.state, stat.tsr};
				`PCITW_REG_XCNT: rData_d = {16'h0, stat.xferCnt};
				default: begin
					rData_d = 32'h0;
					rResp_d = `PCITW_RESP_SLVERR;
				end
			endcase
		end
		// readies registered so every port leaves a flip-flop
		awReady_d = !awHave_d && !bValid_d;
		wReady_d = !wHave_d && !bValid_d;
		arReady_d = !rValid_d;
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			awHave_q <= 1'b0;
			wHave_q <= 1'b0;
			awAddr_q <= 4'h0;
			wData_q <= 32'h0;
			wStrb_q <= 4'h0;
			bValid_q <= 1'b0;
			bResp_q <= 2'h0;
			rValid_q <= 1'b0;
			rResp_q <= 2'h0;
			rData_q <= 32'h0;
			ctrl_q <= `PCITW_CTRL_RST;
			base_q <= `PCITW_BASE_RST;
			awReady_q <= 1'b1;
			wReady_q <= 1'b1;
			arReady_q <= 1'b1;
		end else if (clkEn) begin
			awHave_q <= awHave_d;
			wHave_q <= wHave_d;
			awAddr_q <= awAddr_d;
			wData_q <= wData_d;
			wStrb_q <= wStrb_d;
			bValid_q <= bValid_d;
			bResp_q <= bResp_d;
			rValid_q <= rValid_d;
			rResp_q <= rResp_d;
			rData_q <= rData_d;
			ctrl_q <= ctrl_d;
			base_q <= base_d;
			awReady_q <= awReady_d;
			wReady_q <= wReady_d;
			arReady_q <= arReady_d;
		end
	end

	assign s_axi_awready = awReady_q;
	assign s_axi_wready = wReady_q;
	assign s_axi_bvalid = bValid_q;
	assign s_axi_bresp = bResp_q;
	assign s_axi_arready = arReady_q;
	assign s_axi_rvalid = rValid_q;
	assign s_axi_rdata = rData_q;
	assign s_axi_rresp = rResp_q;
	assign cfg.memEn = ctrl_q[`PCITW_CTRL_MEMEN];
	assign cfg.ioEn = ctrl_q[`PCITW_CTRL_IOEN];
	assign cfg.base = base_q;

endmodule

`default_nettype wire

// ### src/pcitw_params.svh
`ifndef PCITW_PARAMS_SVH
`define PCITW_PARAMS_SVH

// ------------------------------------------------------------
// register map
// ------------------------------------------------------------
`define PCITW_REG_CTRL 4'h0
`define PCITW_REG_BASE 4'h4
`define PCITW_REG_STAT 4'h8
`define PCITW_REG_XCNT 4'hc
`define PCITW_CTRL_RST 32'h0000_0003
`define PCITW_BASE_RST 32'h0000_0000
`define PCITW_CTRL_MEMEN 0
`define PCITW_CTRL_IOEN 1

// ------------------------------------------------------------
// bus commands and address decode
// ------------------------------------------------------------
`define PCITW_CMD_IOWR 4'h3
`define PCITW_CMD_MEMWR 4'h7
`define PCITW_CMD_CFGWR 4'hb
`define PCITW_CMD_MWI 4'hf
`define PCITW_QW_LOW 3'h0
`define PCITW_QW_HIGH 3'h4

// ------------------------------------------------------------
// status vector bits
// ------------------------------------------------------------
`define PCITW_TSR_W 12
`define PCITW_TSR_64 7
`define PCITW_TSR_BUSY 8
`define PCITW_TSR_BURST 9
`define PCITW_TSR_XFER 10

// ------------------------------------------------------------
// bus answers
// ------------------------------------------------------------
`define PCITW_RESP_OKAY 2'h0
`define PCITW_RESP_SLVERR 2'h2

`endif

// ### src/pcitw_pkg.sv
package pcitw_pkg;

	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_DEVSEL = 7'h02,
		ST_DATA = 7'h04,
		ST_RETRY = 7'h08,
		ST_DISC = 7'h10,
		ST_ABORT = 7'h20,
		ST_TURN = 7'h40
	} pcitw_state_t;

	typedef struct packed {
		logic memEn;
		logic ioEn;
		logic [31:0] base;
	} pcitw_cfg_t;

	typedef struct packed {
		logic [11:0] tsr;
		logic [6:0] state;
		logic [15:0] xferCnt;
	} pcitw_stat_t;

endpackage

// ### src/pcitw_target.sv
// Summary of operation
// - local not ready: drop local_xfer_n next cycle
// - next cycle, deassert trdy to stall bus
// - 32-bit words land on local bits 31:0
// - start address bit 2 picks first dword half
// - no req64: devsel without ack64
// - 32-bit pending: status bit 7 low
// - dword acks alternate during 32-bit burst
// - unaligned start holds high ack until transfer
// - 32-bit burst: bit 7 low, bit 9 high
// - io write sequenced like 32-bit single write
// - config writes self-completed, ignore local ready
// - no local terminations during config
// - disconnect request yields retry or disconnect
// - abort request yields target abort
// - retry: devsel and stop, no trdy
// - request before ready: retry, else disconnect
// - retry only before any data moved
// - frame and irdy after address: burst bit 9
// - status bit 10: bus transfer last cycle
// - local transfer: ack now, ready last cycle
`timescale 1ns/10ps
`default_nettype none
`include "pcitw_params.svh"

module pcitw_target
	import pcitw_pkg::*;
#(
	parameter bit LOCAL64 = 1'b1,
	parameter int BAR_LSB = 12
)(
	// clock, reset, enable
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic clkEn,
	// pci bus inputs
	input wire logic [31:0] ad,
	input wire logic [31:0] ad_hi,
	input wire logic [3:0] cbe_n,
	input wire logic [3:0] cbe_hi_n,
	input wire logic frame_n,
	input wire logic irdy_n,
	input wire logic idsel,
	input wire logic req64_n,
	// pci target controls, sustained three-state
	output logic devsel_n_o,
	output logic devsel_oe,
	output logic trdy_n_o,
	output logic trdy_oe,
	output logic stop_n_o,
	output logic stop_oe,
	output logic ack64_n_o,
	output logic ack64_oe,
	// local side
	input wire logic local_ready_n,
	input wire logic disconnect_req_n,
	input wire logic abort_req_n,
	output logic local_frame_n,
	output logic local_ack_n,
	output logic local_xfer_n,
	output logic low_dword_ack_n,
	output logic high_dword_ack_n,
	output logic [63:0] local_data_out,
	output logic [7:0] local_be_out,
	output logic [3:0] local_cmd_out,
	output logic [11:0] target_status_vec,
	// axi4-lite register slave
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	pcitw_cfg_t cfg;
	pcitw_stat_t stat;
	pcitw_state_t state_q, state_d;
	logic framePrevN_q, framePrevN_d;
	logic cfgTr_q, cfgTr_d, is64_q, is64_d, hi_q, hi_d;
	logic dataDone_q, dataDone_d, readySeen_q, readySeen_d;
	logic devselN_q, devselN_d, trdyN_q, trdyN_d, stopN_q, stopN_d;
	logic ack64N_q, ack64N_d, ctlOe_q, ctlOe_d;
	logic lFrameN_q, lFrameN_d, lAckN_q, lAckN_d, lXferN_q, lXferN_d;
	logic lowAckN_q, lowAckN_d, highAckN_q, highAckN_d;
	logic [63:0] lData_q, lData_d;
	logic [7:0] lBe_q, lBe_d;
	logic [3:0] lCmd_q, lCmd_d;
	logic [11:0] tsr_q, tsr_d;
	logic [15:0] xferCnt_q, xferCnt_d;
	logic pciXfer, keep, ackNext, lXferNow, hiNext, active, hit, baseMatch;

	function automatic logic [11:0] tsrBit(input int idx);
		return 12'(1) << idx;
	endfunction

	// ------------------------------------------------------------
	// next-state logic
	// ------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		framePrevN_d = frame_n;
		cfgTr_d = cfgTr_q;
		is64_d = is64_q;
		dataDone_d = dataDone_q;
		readySeen_d = readySeen_q;
		devselN_d = devselN_q;
		trdyN_d = trdyN_q;
		stopN_d = stopN_q;
		ack64N_d = ack64N_q;
		ctlOe_d = ctlOe_q;
		lData_d = lData_q;
		lBe_d = lBe_q;
		lCmd_d = lCmd_q;
		xferCnt_d = xferCnt_q;
		pciXfer = !irdy_n && !trdyN_q && ctlOe_q;
		lXferNow = !lXferN_q;
		keep = !lAckN_q && lXferN_q;
		// data lands in the buffer only for local transactions
		ackNext = (pciXfer && !cfgTr_q) || keep;
		// 32-bit words walk through the qword halves
		hiNext = hi_q ^ (lXferNow && !is64_q);
		hi_d = hiNext;
		active = !(state_q inside {ST_IDLE, ST_TURN});
		baseMatch = ad[31:BAR_LSB] == cfg.base[31:BAR_LSB];
		hit = 1'b0;
		if (lXferNow) begin
			xferCnt_d = xferCnt_q + 16'h1;
		end
		if (pciXfer && !cfgTr_q) begin
			lData_d = is64_q ? {ad_hi, ad} : {32'h0, ad};
			lBe_d = is64_q ? ~{cbe_hi_n, cbe_n} : {4'h0, ~cbe_n};
		end
		tsr_d = 12'h0;
		case (state_q)
			ST_IDLE: begin
				// address phase is the first cycle frame is seen low
				if (!frame_n && framePrevN_q) begin
					case (cbe_n)
						`PCITW_CMD_MEMWR, `PCITW_CMD_MWI: hit = cfg.memEn && baseMatch;
						// low address bits against byte enables not checked here
						`PCITW_CMD_IOWR: hit = cfg.ioEn && baseMatch;
						`PCITW_CMD_CFGWR: hit = idsel && ad[1:0] == 2'h0;
						default: hit = 1'b0;
					endcase
				end
				if (hit) begin
					state_d = ST_DEVSEL;
					lCmd_d = cbe_n;
					cfgTr_d = cbe_n == `PCITW_CMD_CFGWR;
					// io and config writes are always 32 bits
					is64_d = LOCAL64 && !req64_n && cbe_n != `PCITW_CMD_IOWR
						&& cbe_n != `PCITW_CMD_CFGWR;
					hi_d = LOCAL64 && ad[2:0] == `PCITW_QW_HIGH;
					dataDone_d = 1'b0;
					readySeen_d = 1'b0;
					devselN_d = 1'b0;
					ack64N_d = !(LOCAL64 && !req64_n && cbe_n == `PCITW_CMD_MEMWR
						|| LOCAL64 && !req64_n && cbe_n == `PCITW_CMD_MWI);
					trdyN_d = 1'b1;
					stopN_d = 1'b1;
					ctlOe_d = 1'b1;
				end
			end
			ST_DEVSEL, ST_DATA: begin
				state_d = ST_DATA;
				if (!local_ready_n) begin
					readySeen_d = 1'b1;
				end
				if (pciXfer) begin
					dataDone_d = 1'b1;
				end
				// config cycles take data regardless of local readiness
				trdyN_d = !(cfgTr_q || !local_ready_n);
				if (pciXfer && frame_n || frame_n && irdy_n && state_q == ST_DATA) begin
					state_d = ST_TURN;
					devselN_d = 1'b1;
					trdyN_d = 1'b1;
					stopN_d = 1'b1;
					ack64N_d = 1'b1;
				end else if (!cfgTr_q && !abort_req_n) begin
					state_d = ST_ABORT;
					devselN_d = 1'b1;
					trdyN_d = 1'b1;
					stopN_d = 1'b0;
					ack64N_d = 1'b1;
				end else if (!cfgTr_q && !disconnect_req_n) begin
					stopN_d = 1'b0;
					if (!dataDone_q && !pciXfer && !readySeen_q && local_ready_n
						&& lAckN_q) begin
						state_d = ST_RETRY;
						trdyN_d = 1'b1;
					end else begin
						state_d = ST_DISC;
					end
				end
			end
			ST_RETRY, ST_ABORT, ST_DISC: begin
				if (pciXfer) begin
					trdyN_d = 1'b1;
				end
				if (frame_n) begin
					state_d = ST_TURN;
					devselN_d = 1'b1;
					trdyN_d = 1'b1;
					stopN_d = 1'b1;
					ack64N_d = 1'b1;
				end
			end
			ST_TURN: begin
				state_d = ST_IDLE;
				ctlOe_d = 1'b0;
			end
			default: begin
				state_d = ST_IDLE;
				ctlOe_d = 1'b0;
			end
		endcase
		// local frame covers non-config transactions and the pipeline drain
		lFrameN_d = !(!cfgTr_d && (state_d inside {ST_DEVSEL, ST_DATA, ST_RETRY,
			ST_DISC, ST_ABORT} || ackNext));
		lAckN_d = !ackNext;
		lXferN_d = !(ackNext && !local_ready_n);
		// in 32-bit mode one half is acknowledged, held until its transfer
		lowAckN_d = lFrameN_d || !is64_d && hi_d;
		highAckN_d = lFrameN_d || !is64_d && !hi_d;
		if (active) begin
			tsr_d[`PCITW_TSR_BUSY] = 1'b1;
			tsr_d[`PCITW_TSR_64] = is64_q;
			// burst seen once frame and irdy are low after the address
			tsr_d[`PCITW_TSR_BURST] = tsr_q[`PCITW_TSR_BURST]
				|| !frame_n && !irdy_n;
		end
		tsr_d = tsr_d | (pciXfer ? tsrBit(`PCITW_TSR_XFER) : 12'h0);
	end

	// ------------------------------------------------------------
	// state registers
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			state_q <= ST_IDLE;
			framePrevN_q <= 1'b1;
			cfgTr_q <= 1'b0;
			is64_q <= 1'b0;
			hi_q <= 1'b0;
			dataDone_q <= 1'b0;
			readySeen_q <= 1'b0;
			devselN_q <= 1'b1;
			trdyN_q <= 1'b1;
			stopN_q <= 1'b1;
			ack64N_q <= 1'b1;
			ctlOe_q <= 1'b0;
			lFrameN_q <= 1'b1;
			lAckN_q <= 1'b1;
			lXferN_q <= 1'b1;
			lowAckN_q <= 1'b1;
			highAckN_q <= 1'b1;
			lData_q <= 64'h0;
			lBe_q <= 8'h0;
			lCmd_q <= 4'h0;
			tsr_q <= 12'h0;
			xferCnt_q <= 16'h0;
		end else if (clkEn) begin
			state_q <= state_d;
			framePrevN_q <= framePrevN_d;
			cfgTr_q <= cfgTr_d;
			is64_q <= is64_d;
			hi_q <= hi_d;
			dataDone_q <= dataDone_d;
			readySeen_q <= readySeen_d;
			devselN_q <= devselN_d;
			trdyN_q <= trdyN_d;
			stopN_q <= stopN_d;
			ack64N_q <= ack64N_d;
			ctlOe_q <= ctlOe_d;
			lFrameN_q <= lFrameN_d;
			lAckN_q <= lAckN_d;
			lXferN_q <= lXferN_d;
			lowAckN_q <= lowAckN_d;
			highAckN_q <= highAckN_d;
			lData_q <= lData_d;
			lBe_q <= lBe_d;
			lCmd_q <= lCmd_d;
			tsr_q <= tsr_d;
			xferCnt_q <= xferCnt_d;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign devsel_n_o = devselN_q;
	assign trdy_n_o = trdyN_q;
	assign stop_n_o = stopN_q;
	assign ack64_n_o = ack64N_q;
	assign devsel_oe = ctlOe_q;
	assign trdy_oe = ctlOe_q;
	assign stop_oe = ctlOe_q;
	assign ack64_oe = ctlOe_q;
	assign local_frame_n = lFrameN_q;
	assign local_ack_n = lAckN_q;
	assign local_xfer_n = lXferN_q;
	assign low_dword_ack_n = lowAckN_q;
	assign high_dword_ack_n = highAckN_q;
	assign local_data_out = lData_q;
	assign local_be_out = lBe_q;
	assign local_cmd_out = lCmd_q;
	assign target_status_vec = tsr_q;
	assign stat.tsr = tsr_q;
	assign stat.state = state_q;
	assign stat.xferCnt = xferCnt_q;

	// ------------------------------------------------------------
	// register slave
	// ------------------------------------------------------------
	pcitw_axil_regs u_regs (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.clkEn(clkEn),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.cfg(cfg),
		.stat(stat)
	);

endmodule

`default_nettype wire

// ### verification/pcitw_pci_master.sv
`timescale 1ns/10ps
`default_nettype none

module pcitw_pci_master (
	// clock and target answers
	input wire logic sys_clk,
	input wire logic trdyW,
	input wire logic stopW,
	// master drive
	output logic [31:0] ad,
	output logic [3:0] cbe_n,
	output logic frame_n,
	output logic irdy_n,
	output logic idsel
);
	logic [31:0] wr [0:8];
	int nx = 0;
	bit tmo = 0;

	initial begin
		ad = 32'h0;
		cbe_n = 4'hf;
		frame_n = 1'b1;
		irdy_n = 1'b1;
		idsel = 1'b0;
	end

	// ------------------------------------------------------------
	// one write transaction, ends on last phase or stop
	// ------------------------------------------------------------
	task automatic run(input logic [3:0] c, input logic [31:0] a, input int n, input logic s);
		int t;
		nx = 0;
		frame_n <= 1'b0;
		ad <= a;
		cbe_n <= c;
		idsel <= s;
		@(posedge sys_clk);
		idsel <= 1'b0;
		irdy_n <= 1'b0;
		ad <= wr[0];
		cbe_n <= 4'h0;
		frame_n <= (n == 1);
		for (t = 0; t < 64; t++) begin
			@(posedge sys_clk);
			if (!trdyW && !irdy_n) begin
				nx++;
			end
			if (nx >= n || (!stopW && frame_n))
				break;
			// one drive per edge; stop ends the burst at the next phase
			ad <= wr[nx];
			frame_n <= (nx >= n - 1) || !stopW;
		end
		tmo = (t == 64);
		frame_n <= 1'b1;
		irdy_n <= 1'b1;
		// released bus must not keep its last value
		ad <= ~ad;
		cbe_n <= 4'hf;
	endtask
endmodule
`default_nettype wire

// ### verification/pcitw_target_sva.sv
`timescale 1ns/10ps
`default_nettype none

module pcitw_target_sva (
	// clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// pci side
	input wire logic [31:0] ad,
	input wire logic frame_n,
	input wire logic irdy_n,
	input wire logic req64_n,
	input wire logic devsel_n_o,
	input wire logic devsel_oe,
	input wire logic trdy_n_o,
	input wire logic trdy_oe,
	input wire logic stop_n_o,
	input wire logic stop_oe,
	input wire logic ack64_n_o,
	// local side
	input wire logic local_ready_n,
	input wire logic disconnect_req_n,
	input wire logic abort_req_n,
	input wire logic local_frame_n,
	input wire logic local_ack_n,
	input wire logic local_xfer_n,
	input wire logic low_dword_ack_n,
	input wire logic high_dword_ack_n,
	input wire logic [63:0] local_data_out,
	input wire logic [11:0] target_status_vec
);
	logic pciXfer;
	assign pciXfer = !irdy_n && !trdy_n_o && trdy_oe;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!nrst);

	property p_ready_drop;
		local_ready_n |=> local_xfer_n;
	endproperty
	a_ready_drop: assert property (p_ready_drop) else $error("local transfer without ready");

	property p_trdy_stall;
		local_ready_n && disconnect_req_n && !local_frame_n |=> trdy_n_o;
	endproperty
	a_trdy_stall: assert property (p_trdy_stall) else $error("trdy low while local stalled");

	property p_low_data;
		pciXfer && !local_frame_n |=> !local_ack_n && local_data_out == {32'h0, $past(ad)};
	endproperty
	a_low_data: assert property (p_low_data) else $error("local data not bus word");

	property p_no_ack64;
		req64_n && devsel_oe |-> ack64_n_o;
	endproperty
	a_no_ack64: assert property (p_no_ack64) else $error("wide ack on narrow cycle");

	property p_narrow_stat;
		!local_frame_n && req64_n |-> !target_status_vec[7];
	endproperty
	a_narrow_stat: assert property (p_narrow_stat) else $error("wide status on narrow cycle");

	property p_burst_bit;
		!frame_n && !irdy_n && !local_frame_n && stop_n_o && devsel_oe |=> target_status_vec[9];
	endproperty
	a_burst_bit: assert property (p_burst_bit) else $error("burst bit missing");

	property p_halves;
		!local_frame_n && !$past(local_frame_n) |->
			(low_dword_ack_n != $past(low_dword_ack_n)) == !$past(local_xfer_n)
			&& low_dword_ack_n != high_dword_ack_n;
	endproperty
	a_halves: assert property (p_halves) else $error("dword halves out of step");

	property p_bus_done;
		pciXfer && !local_frame_n |=> target_status_vec[10];
	endproperty
	a_bus_done: assert property (p_bus_done) else $error("bus transfer bit missing");

	property p_local_xfer;
		!local_xfer_n |-> !local_ack_n && !$past(local_ready_n);
	endproperty
	a_local_xfer: assert property (p_local_xfer) else $error("local transfer unqualified");

	property p_abort;
		!abort_req_n && !local_frame_n && devsel_oe && !devsel_n_o
			|-> ##[1:4] (stop_oe && !stop_n_o && devsel_n_o);
	endproperty
	a_abort: assert property (p_abort) else $error("abort request not honoured");

	property p_cfg_quiet;
		devsel_oe && !devsel_n_o && local_frame_n |-> stop_n_o;
	endproperty
	a_cfg_quiet: assert property (p_cfg_quiet) else $error("stop during config cycle");
endmodule
`default_nettype wire

// ### verification/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`include "pcitw_params.svh"

module testbench;
	localparam logic [31:0] BASEV = 32'h4a3c_5000;
	logic sys_clk, nrst, clkEn, frame_n, irdy_n, idsel, req64_n, trdyW, stopW;
	logic [31:0] ad, ad_hi, s_axi_wdata, s_axi_rdata;
	logic [3:0] cbe_n, cbe_hi_n, s_axi_awaddr, s_axi_araddr, s_axi_wstrb, local_cmd_out;
	logic devsel_n_o, devsel_oe, trdy_n_o, trdy_oe, stop_n_o, stop_oe, ack64_n_o, ack64_oe;
	logic local_ready_n = 1'b1;
	logic disconnect_req_n, abort_req_n, local_frame_n, local_ack_n, local_xfer_n;
	logic low_dword_ack_n, high_dword_ack_n;
	logic [63:0] local_data_out;
	logic [7:0] local_be_out;
	logic [11:0] target_status_vec;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [15:0] rdyPat = 16'hffff;
	logic [3:0] expCmd;
	logic [31:0] expQ[$];
	bit hiNext;
	int errors = 0, compares = 0, term = 0, locCnt = 0;

	assign trdyW = trdy_oe ? trdy_n_o : 1'b1;
	assign stopW = stop_oe ? stop_n_o : 1'b1;

	pcitw_target dut_u (.*);
	pcitw_pci_master pm (.sys_clk, .trdyW, .stopW, .ad, .cbe_n, .frame_n, .irdy_n, .idsel);

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	task automatic close_out;
		$display("compares=%0d errors=%0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
		compares++;
		if (g !== e) begin
			errors++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask

	// ------------------------------------------------------------
	// register bus master
	// ------------------------------------------------------------
	task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
			output logic [1:0] r);
		int t;
		bit aw = 0, w = 0, b = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (t = 0; t < 50 && !b; t++) begin
			@(posedge sys_clk);
			if (s_axi_awready && !aw) begin
				aw = 1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wready && !w) begin
				w = 1;
				s_axi_wvalid <= 1'b0;
			end
			if (s_axi_bvalid) begin
				b = 1;
				r = s_axi_bresp;
			end
		end
		s_axi_bready <= 1'b0;
		@(posedge sys_clk);
		if (!b) begin
			errors++;
			close_out();
		end
	endtask

	task automatic axr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		int t;
		bit ar = 0, g = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (t = 0; t < 50 && !g; t++) begin
			@(posedge sys_clk);
			if (s_axi_arready && !ar) begin
				ar = 1;
				s_axi_arvalid <= 1'b0;
			end
			if (s_axi_rvalid) begin
				g = 1;
				d = s_axi_rdata;
				r = s_axi_rresp;
			end
		end
		s_axi_rready <= 1'b0;
		@(posedge sys_clk);
		if (!g) begin
			errors++;
			close_out();
		end
	endtask

	// ------------------------------------------------------------
	// local side: ready pattern, transfer model, termination watch
	// ------------------------------------------------------------
	always @(posedge sys_clk) begin
		local_ready_n <= rdyPat[0];
		rdyPat <= {rdyPat[15], rdyPat[15:1]};
		if (stopW === 1'b0) begin
			term = devsel_n_o ? 2 : 1;
			chk("ack64", 2'h3, {ack64_oe, ack64_n_o});
		end
		if (nrst && local_xfer_n === 1'b0) begin
			locCnt++;
			if (expQ.size() == 0)
				chk("spareXfer", 0, 1);
			else begin
				chk("localData", {32'h0, expQ.pop_front()}, local_data_out);
				chk("byteEn", 8'h0f, local_be_out);
				chk("lowAck", hiNext, low_dword_ack_n);
				chk("highAck", !hiNext, high_dword_ack_n);
				chk("cmd", expCmd, local_cmd_out);
				hiNext = !hiNext;
			end
		end
	end

	task automatic xact(input logic [3:0] c, input logic [31:0] a, input int n, input logic s,
			input logic [15:0] p, input int k);
		int i;
		#1 rdyPat = p;
		term = 0;
		expCmd = c;
		hiNext = a[2];
		for (i = 0; i < n; i++) begin
			pm.wr[i] = $urandom;
			if (i < k)
				expQ.push_back(pm.wr[i]);
		end
		repeat (2) @(posedge sys_clk);
		pm.run(c, a, n, s);
		repeat (6) @(posedge sys_clk);
		if (pm.tmo) begin
			errors++;
			close_out();
		end
	endtask

	initial begin
		logic [31:0] d;
		logic [1:0] r;
		logic [31:0] a;
		nrst = 1'b0;
		clkEn = 1'b1;
		ad_hi = 32'h0;
		cbe_hi_n = 4'hf;
		req64_n = 1'b1;
		disconnect_req_n = 1'b1;
		abort_req_n = 1'b1;
		{s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		d = $urandom(32'h3a67);
		repeat (3) @(posedge sys_clk);
		nrst <= 1'b1;
		@(posedge sys_clk);
		axr(`PCITW_REG_CTRL, d, r);
		chk("ctrlReset", `PCITW_CTRL_RST, d);
		axw(`PCITW_REG_BASE, BASEV, 4'hf, r);
		axw(`PCITW_REG_BASE, 32'h0, 4'h0, r);
		chk("bresp", `PCITW_RESP_OKAY, r);
		axr(`PCITW_REG_BASE, d, r);
		chk("base", BASEV, d);
		axw(`PCITW_REG_XCNT, 32'hffff, 4'hf, r);
		chk("roResp", `PCITW_RESP_OKAY, r);
		axr(4'h2, d, r);
		chk("unmapped", `PCITW_RESP_SLVERR, r);
		a = BASEV + (($urandom % 256) << 3);
		xact(`PCITW_CMD_MEMWR, a, 1, 1'b0, 16'h0, 1);
		chk("singleNx", 1, pm.nx);
		xact(`PCITW_CMD_MEMWR, a + 4, 4, 1'b0, 16'h0030, 4);
		chk("burstNx", 4, pm.nx);
		xact(`PCITW_CMD_MWI, a, 2, 1'b0, 16'h0, 2);
		chk("left", 0, expQ.size());
		// low address bits 00 with all byte lanes on: a valid io pair
		xact(`PCITW_CMD_IOWR, a, 1, 1'b0, 16'h0, 1);
		chk("ioNx", 1, pm.nx);
		disconnect_req_n <= 1'b0;
		abort_req_n <= 1'b0;
		xact(`PCITW_CMD_CFGWR, {$urandom} & 32'hffff_fffc, 1, 1'b1, 16'hffff, 0);
		chk("cfgNx", 1, pm.nx);
		chk("cfgTerm", 0, term);
		abort_req_n <= 1'b1;
		xact(`PCITW_CMD_MEMWR, a, 2, 1'b0, 16'hffff, 0);
		chk("retryNx", 0, pm.nx);
		chk("retryTerm", 1, term);
		xact(`PCITW_CMD_MEMWR, a, 4, 1'b0, 16'h0, 4);
		chk("discTerm", 1, term);
		chk("discData", 1, expQ.size() > 0 && expQ.size() < 4);
		expQ.delete();
		disconnect_req_n <= 1'b1;
		abort_req_n <= 1'b0;
		xact(`PCITW_CMD_MEMWR, a, 2, 1'b0, 16'hffff, 0);
		chk("abortTerm", 2, term);
		abort_req_n <= 1'b1;
		axr(`PCITW_REG_XCNT, d, r);
		chk("xferCount", locCnt[15:0], d[15:0]);
		close_out();
	end
endmodule

bind pcitw_target pcitw_target_sva chk_u (.sys_clk, .nrst, .ad, .frame_n, .irdy_n, .req64_n,
	.devsel_n_o, .devsel_oe, .trdy_n_o, .trdy_oe, .stop_n_o, .stop_oe, .ack64_n_o,
	.local_ready_n, .disconnect_req_n, .abort_req_n, .local_frame_n, .local_ack_n,
	.local_xfer_n, .low_dword_ack_n, .high_dword_ack_n, .local_data_out, .target_status_vec);
`default_nettype wire
